/* src/bct_unit.sv */
// Purpose: Address compare, trace FIFO and halt request unit on the CPU bus.
// Assumes: All inputs but rst_b_i come from logic on clk_i; register port is byte wide.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps

module bct_unit #(
    parameter int DEPTH = bct_pkg::FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic cpu_cycle_i,
    input wire logic [15:0] cpu_addr_i,
    input wire logic cpu_rd_i,
    input wire logic cpu_fetch_i,
    input wire logic [7:0] cpu_data_i,
    input wire logic secure_i,
    output logic cpu_halt_o,
    output logic cpu_halt_tag_o,
    output logic run_active_o
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    typedef struct packed {
        bct_pkg::bct_run_t run;
        logic [7:0] cah;
        logic [7:0] cal;
        logic [7:0] cbh;
        logic [7:0] cbl;
        logic [7:0] ctrl;
        logic [7:0] trg;
        logic [DEPTH-1:0][15:0] fifo;
        logic [CW-1:0] cnt;
        logic af;
        logic bf;
        logic a_seen;
        logic [15:0] last_fetch;
        logic [7:0] rdata;
        logic halt;
        logic halt_tag;
    } bct_state_t;

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    // Assertion is asynchronous; release is aligned to clk_i by two flops
    logic rst_meta_b;
    logic rst_b;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_b <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_b <= rst_meta_b;
        end
    end

    // ----------------------------------------
    // Match logic
    // ----------------------------------------
    function automatic logic dir_ok(input logic qualify, input logic value, input logic rd);
        dir_ok = !qualify || (value == rd);
    endfunction

    bct_state_t st_reg;
    bct_state_t st_next;
    logic armed;
    logic event_only;
    logic begin_trace;
    logic [15:0] comp_a;
    logic [15:0] comp_b;
    logic a_hit;
    logic b_hit;
    logic trig;
    logic push;
    logic [15:0] push_word;
    logic rd_fifo_low;
    logic rd_fifo_high;
    logic ctrl_wr;
    logic start;

    assign armed = st_reg.run != bct_pkg::RUN_IDLE;
    assign comp_a = {st_reg.cah, st_reg.cal};
    assign comp_b = {st_reg.cbh, st_reg.cbl};
    assign event_only = st_reg.trg[3:0] == bct_pkg::TRG_EVENT_B
        || st_reg.trg[3:0] == bct_pkg::TRG_A_THEN_EVENT_B;
    assign begin_trace = event_only || st_reg.trg[bct_pkg::BIT_TRIG_BEGIN];
    assign rd_fifo_low = reg_rd_i && reg_addr_i == bct_pkg::OFS_FIFO_LOW;
    assign rd_fifo_high = reg_rd_i && reg_addr_i == bct_pkg::OFS_FIFO_HIGH;
    assign ctrl_wr = reg_wr_i && reg_addr_i == bct_pkg::OFS_WATCH_CONTROL;
    // Secured state only refuses turning enable on; an enabled unit may still arm
    assign start = ctrl_wr && !armed && reg_wdata_i[bct_pkg::BIT_RUN_ARM]
        && reg_wdata_i[bct_pkg::BIT_UNIT_ENABLE] && (!secure_i || st_reg.ctrl[bct_pkg::BIT_UNIT_ENABLE]);

    // Tag qualification only counts opcode fetches; halt timing is unaffected
    always_comb begin
        a_hit = armed && cpu_cycle_i && cpu_addr_i == comp_a
            && dir_ok(st_reg.ctrl[bct_pkg::BIT_DIR_QUALIFY_A], st_reg.ctrl[bct_pkg::BIT_DIR_VALUE_A], cpu_rd_i)
            && (!st_reg.trg[bct_pkg::BIT_TRIG_QUALIFY_SELECT] || cpu_fetch_i);
        b_hit = armed && cpu_cycle_i && cpu_addr_i == comp_b
            && dir_ok(st_reg.ctrl[bct_pkg::BIT_DIR_QUALIFY_B], st_reg.ctrl[bct_pkg::BIT_DIR_VALUE_B], cpu_rd_i)
            && (!st_reg.trg[bct_pkg::BIT_TRIG_QUALIFY_SELECT] || cpu_fetch_i);
        // Range modes compare the raw address; direction and tag do not apply
        case (st_reg.trg[3:0])
            bct_pkg::TRG_A_ONLY: trig = a_hit;
            bct_pkg::TRG_A_OR_B: trig = a_hit || b_hit;
            bct_pkg::TRG_A_THEN_B: trig = st_reg.a_seen && b_hit;
            bct_pkg::TRG_EVENT_B: trig = armed;
            bct_pkg::TRG_A_THEN_EVENT_B: trig = a_hit;
            bct_pkg::TRG_A_AND_B_DATA: trig = a_hit && cpu_data_i == st_reg.cbl;
            bct_pkg::TRG_A_NOT_B_DATA: trig = a_hit && cpu_data_i != st_reg.cbl;
            bct_pkg::TRG_INSIDE: trig = armed && cpu_cycle_i && cpu_addr_i >= comp_a && cpu_addr_i <= comp_b;
            bct_pkg::TRG_OUTSIDE: trig = armed && cpu_cycle_i && (cpu_addr_i < comp_a || cpu_addr_i > comp_b);
            default: trig = 1'b0;
        endcase
        // Event-only entries carry one byte in the low half
        push_word = event_only ? {8'h00, cpu_data_i} : cpu_addr_i;
        push = 1'b0;
        if (st_reg.run == bct_pkg::RUN_FILL) begin
            push = event_only ? b_hit : (cpu_cycle_i && cpu_fetch_i);
        end else if (st_reg.run == bct_pkg::RUN_CIRC) begin
            push = cpu_cycle_i && cpu_fetch_i;
        end
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.halt = 1'b0;
        if (cpu_cycle_i && cpu_fetch_i) begin
            st_next.last_fetch = cpu_addr_i;
        end
        if (a_hit) begin
            st_next.af = 1'b1;
            st_next.a_seen = 1'b1;
        end
        if (b_hit) begin
            st_next.bf = 1'b1;
        end

        // Pushes enter at the tail; the oldest word drops out of the head
        if (push) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.fifo[i] = st_reg.fifo[i+1];
            end
            st_next.fifo[DEPTH-1] = push_word;
            if (st_reg.cnt != CNT_FULL) begin
                st_next.cnt = st_reg.cnt + CW'(1);
            end
        end

        unique case (st_reg.run)
            bct_pkg::RUN_IDLE: begin
            end
            bct_pkg::RUN_WAIT: begin
                if (trig) begin
                    st_next.run = bct_pkg::RUN_FILL;
                end
            end
            bct_pkg::RUN_FILL: begin
                if (push && st_reg.cnt == CNT_FULL - CW'(1)) begin
                    st_next.run = bct_pkg::RUN_IDLE;
                    st_next.halt = st_reg.ctrl[bct_pkg::BIT_HALT_ENABLE];
                end
            end
            bct_pkg::RUN_CIRC: begin
                if (trig) begin
                    st_next.run = bct_pkg::RUN_IDLE;
                    st_next.halt = st_reg.ctrl[bct_pkg::BIT_HALT_ENABLE];
                end
            end
            default: st_next.run = bct_pkg::RUN_IDLE;
        endcase
        st_next.halt_tag = st_reg.ctrl[bct_pkg::BIT_HALT_TAG];

        // ----------------------------------------
        // Register reads
        // ----------------------------------------
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                bct_pkg::OFS_COMP_A_HIGH: st_next.rdata = st_reg.cah;
                bct_pkg::OFS_COMP_A_LOW: st_next.rdata = st_reg.cal;
                bct_pkg::OFS_COMP_B_HIGH: st_next.rdata = st_reg.cbh;
                bct_pkg::OFS_COMP_B_LOW: st_next.rdata = st_reg.cbl;
                bct_pkg::OFS_FIFO_HIGH: st_next.rdata = event_only ? 8'h00 : st_reg.fifo[0][15:8];
                bct_pkg::OFS_FIFO_LOW: st_next.rdata = st_reg.fifo[0][7:0];
                bct_pkg::OFS_WATCH_CONTROL: st_next.rdata = {st_reg.ctrl[7], armed, st_reg.ctrl[5:0]};
                bct_pkg::OFS_TRIGGER: st_next.rdata = st_reg.trg;
                bct_pkg::OFS_STATUS: st_next.rdata = {st_reg.af, st_reg.bf, armed, 1'b0, 4'(st_reg.cnt)};
                default: st_next.rdata = 8'h00;
            endcase
        end
        // Profiling: while idle each low read shifts and samples the last fetch
        if (rd_fifo_low && !armed) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                st_next.fifo[i] = st_reg.fifo[i+1];
            end
            st_next.fifo[DEPTH-1] = st_reg.last_fetch;
        end

        // ----------------------------------------
        // Register writes
        // ----------------------------------------
        if (reg_wr_i && !armed) begin
            unique case (reg_addr_i)
                bct_pkg::OFS_COMP_A_HIGH: st_next.cah = reg_wdata_i;
                bct_pkg::OFS_COMP_A_LOW: st_next.cal = reg_wdata_i;
                bct_pkg::OFS_COMP_B_HIGH: st_next.cbh = reg_wdata_i;
                bct_pkg::OFS_COMP_B_LOW: st_next.cbl = reg_wdata_i;
                bct_pkg::OFS_TRIGGER: st_next.trg = reg_wdata_i & bct_pkg::TRIG_WRITE_MASK;
                default: begin
                end
            endcase
        end
        // Control is never locked; arming is decided from the written bits
        if (ctrl_wr) begin
            st_next.ctrl = reg_wdata_i;
            st_next.ctrl[bct_pkg::BIT_RUN_ARM] = 1'b0;
            st_next.ctrl[bct_pkg::BIT_UNIT_ENABLE] = reg_wdata_i[bct_pkg::BIT_UNIT_ENABLE]
                && (!secure_i || st_reg.ctrl[bct_pkg::BIT_UNIT_ENABLE]);
            if (!reg_wdata_i[bct_pkg::BIT_RUN_ARM] || !st_next.ctrl[bct_pkg::BIT_UNIT_ENABLE]) begin
                st_next.run = bct_pkg::RUN_IDLE;
            end else if (start) begin
                st_next.run = begin_trace ? bct_pkg::RUN_WAIT : bct_pkg::RUN_CIRC;
                st_next.cnt = '0;
                st_next.af = 1'b0;
                st_next.bf = 1'b0;
                st_next.a_seen = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
            st_reg.run <= bct_pkg::RUN_IDLE;
            st_reg.cah <= bct_pkg::COMP_RESET;
            st_reg.cal <= bct_pkg::COMP_RESET;
            st_reg.cbh <= bct_pkg::COMP_RESET;
            st_reg.cbl <= bct_pkg::COMP_RESET;
            st_reg.ctrl <= bct_pkg::CONTROL_RESET;
            st_reg.trg <= bct_pkg::TRIGGER_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o = st_reg.rdata;
    assign cpu_halt_o = st_reg.halt;
    assign cpu_halt_tag_o = st_reg.halt_tag;
    assign run_active_o = armed;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Checks sleep through reset via the synchronised copy
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b);

    cmp_lock_a: assert property (armed && reg_wr_i && reg_addr_i == bct_pkg::OFS_COMP_A_HIGH
        |=> $stable(st_reg.cah)) else $error("comparator byte changed while armed");
    fh_noshift_a: assert property (rd_fifo_high && !push |=> $stable(st_reg.fifo))
        else $error("fifo high read moved the fifo");
    fl_profile_a: assert property (rd_fifo_low && !armed
        |=> st_reg.fifo[DEPTH-1] == $past(st_reg.last_fetch) && st_reg.fifo[0] == $past(st_reg.fifo[1]))
        else $error("idle fifo low read did not shift and sample");
    armed_hold_a: assert property (armed && rd_fifo_low && !push |=> $stable(st_reg.fifo))
        else $error("armed fifo low read advanced the fifo");
    secure_en_a: assert property (secure_i && !st_reg.ctrl[bct_pkg::BIT_UNIT_ENABLE]
        |=> !st_reg.ctrl[bct_pkg::BIT_UNIT_ENABLE]) else $error("enable set while secured");
    arm_start_a: assert property (start |=> run_active_o && st_reg.cnt == '0 && !st_reg.af)
        else $error("run start did not arm and clear count");
    fill_end_a: assert property (st_reg.run == bct_pkg::RUN_FILL && push && st_reg.cnt == CNT_FULL - CW'(1)
        && !ctrl_wr |=> !run_active_o && st_reg.cnt == CNT_FULL) else $error("full fifo did not end run");
    halt_cause_a: assert property (cpu_halt_o |-> $past(st_reg.ctrl[bct_pkg::BIT_HALT_ENABLE])
        && $past(armed) && !armed) else $error("halt without enable or run end");
    fh_event_a: assert property (rd_fifo_high && event_only |=> reg_rdata_o == 8'h00)
        else $error("fifo high not zero in event-only mode");
    halt_tag_a: assert property (cpu_halt_o |-> cpu_halt_tag_o == $past(st_reg.ctrl[bct_pkg::BIT_HALT_TAG]))
        else $error("halt type differs from tag select");
    // Locks, counts and the halt pulse as seen from outside
    cmp_lock_low_a: assert property (armed && reg_wr_i |=> $stable({st_reg.cal, st_reg.cbh, st_reg.cbl}))
        else $error("comparator low or B byte changed while armed");
    cnt_no_dec_a: assert property (!start |=> st_reg.cnt >= $past(st_reg.cnt))
        else $error("valid count decreased outside a run start");
    halt_off_a: assert property (!st_reg.ctrl[bct_pkg::BIT_HALT_ENABLE] |=> !cpu_halt_o)
        else $error("halt raised with halt enable clear");
    halt_pulse_a: assert property (cpu_halt_o |=> !cpu_halt_o)
        else $error("halt request held beyond one cycle");
    ctrl_write_a: assert property (ctrl_wr |=> st_reg.ctrl[5:0] == $past(reg_wdata_i[5:0]))
        else $error("control bits did not take the written value");
    arm_stop_a: assert property (ctrl_wr && !reg_wdata_i[bct_pkg::BIT_RUN_ARM] |=> !run_active_o)
        else $error("clearing arm did not stop the run");
    idle_quiet_a: assert property (!armed |-> !a_hit && !b_hit && !push)
        else $error("compare or store while not armed");
    wait_no_push_a: assert property (st_reg.run == bct_pkg::RUN_WAIT |-> !push)
        else $error("store before the begin trigger");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    // Covers: begin and end traces, halt, profiling and the inside range trigger
    begin_run_c: cover property (st_reg.run == bct_pkg::RUN_WAIT ##[1:50] st_reg.run == bct_pkg::RUN_FILL);
    end_trace_c: cover property (st_reg.run == bct_pkg::RUN_CIRC && trig);
    halt_c: cover property (cpu_halt_o);
    profile_c: cover property (rd_fifo_low && !armed ##4 rd_fifo_low && !armed);
    range_trig_c: cover property (st_reg.trg[3:0] == bct_pkg::TRG_INSIDE && trig);

endmodule

/* src/bct_pkg.sv */
// Purpose: Shared constants and types of the bus compare and trace unit.
// Assumes: Byte-wide register port; nine register locations.
// Notes:   Offsets are indexes on the byte register port.
package bct_pkg;

    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [3:0] OFS_COMP_A_HIGH = 4'h0;
    localparam logic [3:0] OFS_COMP_A_LOW = 4'h1;
    localparam logic [3:0] OFS_COMP_B_HIGH = 4'h2;
    localparam logic [3:0] OFS_COMP_B_LOW = 4'h3;
    localparam logic [3:0] OFS_FIFO_HIGH = 4'h4;
    localparam logic [3:0] OFS_FIFO_LOW = 4'h5;
    localparam logic [3:0] OFS_WATCH_CONTROL = 4'h6;
    localparam logic [3:0] OFS_TRIGGER = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_UNIT_ENABLE = 7;
    localparam int BIT_RUN_ARM = 6;
    localparam int BIT_HALT_TAG = 5;
    localparam int BIT_HALT_ENABLE = 4;
    localparam int BIT_DIR_VALUE_A = 3;
    localparam int BIT_DIR_QUALIFY_A = 2;
    localparam int BIT_DIR_VALUE_B = 1;
    localparam int BIT_DIR_QUALIFY_B = 0;
    localparam int BIT_TRIG_QUALIFY_SELECT = 7;
    localparam int BIT_TRIG_BEGIN = 6;
    localparam logic [7:0] TRIG_WRITE_MASK = 8'hcf;

    // ----------------------------------------
    // Reset values and sizes
    // ----------------------------------------
    localparam logic [7:0] COMP_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TRIGGER_RESET = 8'h00;
    localparam int FIFO_DEPTH = 8;

    // ----------------------------------------
    // Trigger mode codes
    // ----------------------------------------
    localparam logic [3:0] TRG_A_ONLY = 4'h0;
    localparam logic [3:0] TRG_A_OR_B = 4'h1;
    localparam logic [3:0] TRG_A_THEN_B = 4'h2;
    localparam logic [3:0] TRG_EVENT_B = 4'h3;
    localparam logic [3:0] TRG_A_THEN_EVENT_B = 4'h4;
    localparam logic [3:0] TRG_A_AND_B_DATA = 4'h5;
    localparam logic [3:0] TRG_A_NOT_B_DATA = 4'h6;
    localparam logic [3:0] TRG_INSIDE = 4'h7;
    localparam logic [3:0] TRG_OUTSIDE = 4'h8;

    typedef enum logic [3:0] {
        RUN_IDLE = 4'b0001,
        RUN_WAIT = 4'b0010,
        RUN_FILL = 4'b0100,
        RUN_CIRC = 4'b1000
    } bct_run_t;

endpackage

/* verification/bct_cpu_model.sv */
// Purpose: CPU bus stand-in that issues single address bus cycles.
// Assumes: Cycles launch just after a rising clock edge.
// Notes:   Idle cycles show inverted values so stale data cannot match.
`timescale 1ns/100ps
module bct_cpu_model (
    input wire logic clk_i,
    output logic cycle_o,
    output logic [15:0] addr_o,
    output logic rd_o,
    output logic fetch_o,
    output logic [7:0] data_o
);
    initial begin
        cycle_o = 1'b0;
        addr_o = 16'h0000;
        rd_o = 1'b0;
        fetch_o = 1'b0;
        data_o = 8'h00;
    end
    // Gap idle cycles first; returns just after the edge that samples it
    task automatic cycle(input logic [15:0] a, input logic r, input logic f, input logic [7:0] d, input int g);
        repeat (g) @(posedge clk_i);
        @(posedge clk_i);
        cycle_o <= 1'b1;
        addr_o <= a;
        rd_o <= r;
        fetch_o <= f;
        data_o <= d;
        @(posedge clk_i);
        cycle_o <= 1'b0;
        addr_o <= ~a;
        rd_o <= ~r;
        fetch_o <= 1'b0;
        data_o <= ~d;
    endtask
endmodule

/* verification/bus_compare_trace_debug_tb_top.sv */
// Purpose: Self-checking bench of the compare and trace unit.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   Profiling FIFO is mirrored by a queue model.
`timescale 1ns/100ps
module bus_compare_trace_debug_tb_top;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic secure_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic cpu_cycle_i, cpu_rd_i, cpu_fetch_i, cpu_halt_o, cpu_halt_tag_o, run_active_o;
    logic [15:0] cpu_addr_i, xa, yb, pa, tgt, lo, hi, ma, ha;
    logic [7:0] cpu_data_i, rv, ctl, md, hd;
    logic [1:0] dir;
    logic [15:0] fq[$];
    logic [7:0] dq[$];
    int errors = 0;
    int cmp_count = 0;
    int seed = 32'hd6cae3a8;
    int sel, v, tm;

    always #2.5 clk_i = ~clk_i;

    bct_unit #(.DEPTH(bct_pkg::FIFO_DEPTH)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .cpu_cycle_i(cpu_cycle_i), .cpu_addr_i(cpu_addr_i), .cpu_rd_i(cpu_rd_i), .cpu_fetch_i(cpu_fetch_i),
        .cpu_data_i(cpu_data_i), .secure_i(secure_i), .cpu_halt_o(cpu_halt_o),
        .cpu_halt_tag_o(cpu_halt_tag_o), .run_active_o(run_active_o));
    bct_cpu_model u_cpu (.clk_i(clk_i), .cycle_o(cpu_cycle_i), .addr_o(cpu_addr_i), .rd_o(cpu_rd_i),
        .fetch_o(cpu_fetch_i), .data_o(cpu_data_i));

    // ----------------------------------------
    // Bus tasks and comparisons
    // ----------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %b exp %b", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string m);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        rv = reg_rdata_o;
        chk_byte(rv, exp, m);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        for (int i = 0; i < 8; i++) fq.push_back(16'h0000);
        repeat (3) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        for (int i = 0; i < 10; i++) if (i != 5) rchk(i[3:0], 8'h00, "reset");
        xa = 16'($random(seed));
        yb = xa ^ 16'h5a5a;
        wr(4'h0, xa[15:8]);
        wr(4'h1, xa[7:0]);
        wr(4'h2, yb[15:8]);
        wr(4'h3, yb[7:0]);
        for (int i = 0; i < 4; i++) rchk(i[3:0], i[1] ? yb[15 - 8 * i[0] -: 8] : xa[15 - 8 * i[0] -: 8], "comp");
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            pa = 16'($random(seed));
            u_cpu.cycle(pa, 1'b1, 1'b1, 8'h00, i % 3);
            rchk(bct_pkg::OFS_FIFO_HIGH, fq[0][15:8], "fifo high");
            rchk(bct_pkg::OFS_FIFO_LOW, fq[0][7:0], "fifo low");
            void'(fq.pop_front());
            fq.push_back(pa);
            wr(i[0] ? bct_pkg::OFS_FIFO_HIGH : bct_pkg::OFS_FIFO_LOW, 8'($random(seed)));
        end
        $display("test profiling done");
        for (int k = 0; k < 6; k++) begin
            sel = k / 3;
            v = k % 3;
            tgt = (sel != 0) ? yb : xa;
            dir = (v == 0) ? 2'b00 : {v == 2, 1'b1};
            ctl = {2'b11, k[1], k[0], (sel != 0) ? {2'b00, dir} : {dir, 2'b00}};
            wr(bct_pkg::OFS_TRIGGER, {7'h00, sel[0]});
            wr(bct_pkg::OFS_WATCH_CONTROL, ctl);
            chk_bit(run_active_o, 1'b1, "armed");
            rchk(bct_pkg::OFS_WATCH_CONTROL, ctl, "control");
            rchk(bct_pkg::OFS_FIFO_LOW, fq[0][7:0], "armed low");
            wr(bct_pkg::OFS_COMP_A_HIGH, ~xa[15:8]);
            u_cpu.cycle(tgt ^ (k[0] ? 16'h0100 : 16'h0001), v == 2, 1'b0, 8'h00, 0);
            if (v != 0) u_cpu.cycle(tgt, v == 1, 1'b0, 8'h00, 0);
            #1;
            chk_bit(run_active_o, 1'b1, "no match");
            u_cpu.cycle(tgt, v == 2, 1'b0, 8'h00, 1);
            #1;
            chk_bit(cpu_halt_o, k[0], "halt");
            if (k[0]) chk_bit(cpu_halt_tag_o, k[1], "halt type");
            chk_bit(run_active_o, 1'b0, "run end");
            rchk(bct_pkg::OFS_COMP_A_HIGH, xa[15:8], "locked");
        end
        $display("test compare done");
        for (int m = 3; m < 5; m++) begin
            dq.delete();
            wr(bct_pkg::OFS_TRIGGER, m[7:0]);
            wr(bct_pkg::OFS_WATCH_CONTROL, 8'hd0);
            if (m == 4) u_cpu.cycle(xa, 1'b1, 1'b1, 8'h00, 0);
            for (int i = 0; i < 8; i++) begin
                #1;
                chk_bit(run_active_o, 1'b1, "filling");
                rv = 8'($random(seed));
                u_cpu.cycle(yb + 16'h0001, 1'b0, 1'b0, ~rv, 0);
                u_cpu.cycle(yb, 1'b0, 1'b0, rv, i % 2);
                dq.push_back(rv);
            end
            #1;
            chk_bit(cpu_halt_o, 1'b1, "full halt");
            chk_bit(run_active_o, 1'b0, "full end");
            rchk(bct_pkg::OFS_STATUS, {m == 4, 7'h48}, "status");
            for (int i = 0; i < 8; i++) begin
                rchk(bct_pkg::OFS_FIFO_HIGH, 8'h00, "event high");
                rchk(bct_pkg::OFS_FIFO_LOW, dq[i], "event low");
            end
        end
        $display("test event done");
        lo = 16'($random(seed)) & 16'h3fff;
        hi = lo + 16'h4000;
        wr(bct_pkg::OFS_COMP_A_HIGH, lo[15:8]);
        wr(bct_pkg::OFS_COMP_A_LOW, lo[7:0]);
        wr(bct_pkg::OFS_COMP_B_HIGH, hi[15:8]);
        wr(bct_pkg::OFS_COMP_B_LOW, hi[7:0]);
        for (int j = 0; j < 5; j++) begin
            tm = (j == 0) ? 2 : j + 4;
            ma = (tm == 7) ? hi + 16'h0001 : (tm == 8) ? lo + 16'h0001 : (tm == 2) ? hi : lo;
            ha = (tm == 7) ? lo + 16'h0001 : (tm == 8) ? hi + 16'h0001 : (tm == 2) ? hi : lo;
            md = (tm == 5) ? ~hi[7:0] : hi[7:0];
            hd = (tm == 6) ? ~hi[7:0] : hi[7:0];
            wr(bct_pkg::OFS_TRIGGER, tm[7:0]);
            wr(bct_pkg::OFS_WATCH_CONTROL, 8'hd0);
            u_cpu.cycle(ma, 1'b1, 1'b0, md, 0);
            #1;
            chk_bit(run_active_o, 1'b1, "mode miss");
            if (tm == 2) u_cpu.cycle(lo, 1'b1, 1'b0, 8'h00, 0);
            u_cpu.cycle(ha, 1'b1, 1'b0, hd, 1);
            #1;
            chk_bit(cpu_halt_o, 1'b1, "mode hit");
            chk_bit(run_active_o, 1'b0, "mode end");
        end
        wr(bct_pkg::OFS_TRIGGER, 8'h40);
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'hd0);
        u_cpu.cycle(lo, 1'b1, 1'b0, 8'h00, 0);
        for (int i = 0; i < 8; i++) begin
            #1;
            chk_bit(cpu_halt_o, 1'b0, "begin fill");
            fq[i] = 16'($random(seed));
            u_cpu.cycle(fq[i], 1'b1, 1'b1, 8'h00, i % 2);
        end
        #1;
        chk_bit(cpu_halt_o, 1'b1, "begin halt");
        rchk(bct_pkg::OFS_FIFO_HIGH, fq[0][15:8], "begin high");
        rchk(bct_pkg::OFS_FIFO_LOW, fq[0][7:0], "begin low");
        rchk(bct_pkg::OFS_FIFO_HIGH, fq[1][15:8], "begin next");
        $display("test modes done");
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'h00);
        @(posedge clk_i);
        secure_i <= 1'b1;
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'hc0);
        chk_bit(run_active_o, 1'b0, "secured");
        rchk(bct_pkg::OFS_WATCH_CONTROL, 8'h00, "secured");
        chk_bit(rv[7], 1'b0, "secured enable");
        @(posedge clk_i);
        secure_i <= 1'b0;
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'hc0);
        chk_bit(run_active_o, 1'b1, "arm");
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'h80);
        chk_bit(run_active_o, 1'b0, "stop by arm");
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'hc0);
        wr(bct_pkg::OFS_WATCH_CONTROL, 8'h40);
        chk_bit(run_active_o, 1'b0, "stop by enable");
        $display("test control done");
        complete_run();
    end

    // Whole run needs about five hundred cycles; this leaves ample margin
    initial begin
        #100000;
        errors++;
        complete_run();
    end
endmodule
